/* File: core/scpm_pkg.sv */
// package: constants, modes and carriers of the clock and power-mode controller
package scpm_pkg;
   // ----------------------------------------------------------------
   // oscillator timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_PS  = 10000;     // aclk, 100 MHz
   localparam int unsigned FAST_PERIOD_PS = 125000;    // fast oscillator, 8 MHz
   localparam int unsigned SLOW_PERIOD_PS = 31250000;  // slow oscillator, 32 kHz
   // half periods round down; the modelled oscillators are nominal only
   localparam int unsigned FAST_HALF_CYC  = FAST_PERIOD_PS / (2 * CLK_PERIOD_PS);
   localparam int unsigned SLOW_HALF_CYC  = SLOW_PERIOD_PS / (2 * CLK_PERIOD_PS);
   localparam int unsigned OSC_CNT_W      = 11;
   localparam logic [1:0]  OSC_RDY_EDGES  = 2'h2;

   // ----------------------------------------------------------------
   // register map, field positions, reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL      = 8'h00;
   localparam logic [7:0]  ADDR_EXT       = 8'h04;
   localparam logic [7:0]  ADDR_MODE      = 8'h08;
   localparam int unsigned CTRL_DIV_LSB   = 5;
   localparam int unsigned CTRL_SLOW_RDY  = 3;
   localparam int unsigned CTRL_FAST_RDY  = 2;
   localparam int unsigned CTRL_IDLE_EN   = 1;
   localparam int unsigned CTRL_RANGE     = 0;
   localparam int unsigned EXT_KEEP_SYS   = 7;
   localparam logic [2:0]  RST_DIV        = 3'h0;
   localparam logic        RST_IDLE_EN    = 1'b1;
   localparam logic        RST_RANGE      = 1'b1;
   localparam logic        RST_KEEP_SYS   = 1'b0;
   localparam logic [2:0]  DIV_SLOW_MAX   = 3'h1;
   localparam logic [2:0]  DIV_TOP        = 3'h7;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_DECERR    = 2'h3;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MD_NORMAL = 3'h0,
      MD_SLOW   = 3'h1,
      MD_IDLE_CLOCK_RUNNING  = 3'h3,
      MD_IDLE_CLOCK_STOPPED  = 3'h2,
      MD_SLEEP_WATCHDOG_ALIVE = 3'h6,
      MD_SLEEP_ALL_OFF = 3'h7
   } scpm_mode_t;

   typedef struct packed {
      logic        awvalid;
      logic [7:0]  awaddr;
      logic        wvalid;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bready;
      logic        arvalid;
      logic [7:0]  araddr;
      logic        rready;
   } scpm_axi_req_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } scpm_axi_rsp_t;

   typedef struct packed {
      logic system_clock;
      logic cpu_clock;
      logic timebase_clock;
      logic watchdog_clock;
      logic fast_clock;
   } scpm_clk_t;

   typedef struct packed {
      logic [OSC_CNT_W-1:0] cnt;
      logic                 lvl;
      logic [1:0]           rdy;
   } scpm_osc_st_t;

   typedef struct packed {
      logic en;
      logic out;
   } scpm_gate_st_t;
endpackage : scpm_pkg

/* File: core/scpm_osc.sv */
// oscillator model: a free-running level that starts and stops on request
`timescale 1ns/1ps
module scpm_osc #(
   parameter int unsigned HALF_CYC = 6
) (
   input  wire logic aclk,      // system clock
   input  wire logic aresetn,   // synchronous reset, active low
   input  wire logic enable,    // run request
   output logic      osc_out,   // oscillator level
   output logic      osc_ready  // stable after start-up
);
   localparam int unsigned W = scpm_pkg::OSC_CNT_W;
   localparam logic [W-1:0] LAST = W'(HALF_CYC - 1);

   scpm_pkg::scpm_osc_st_t st;
   scpm_pkg::scpm_osc_st_t n;

   always_comb begin
      n = st;
      // a stop request lets a high phase finish, so the level never truncates
      if (enable || st.lvl) begin
         if (st.cnt == LAST) begin
            n.cnt = '0;
            n.lvl = ~st.lvl;
            if (!st.lvl && st.rdy != scpm_pkg::OSC_RDY_EDGES) begin
               n.rdy = st.rdy + 2'h1;
            end
         end else begin
            n.cnt = st.cnt + W'(1);
         end
      end else begin
         n.cnt = '0;
         n.rdy = 2'h0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= n;
      end
   end

   assign osc_out   = st.lvl;
   assign osc_ready = (st.rdy == scpm_pkg::OSC_RDY_EDGES);
endmodule : scpm_osc

/* File: core/scpm_clk_gate.sv */
// clock gate: the enable is taken only while the input clock level is low
`timescale 1ns/1ps
module scpm_clk_gate (
   input  wire logic aclk,     // system clock
   input  wire logic aresetn,  // synchronous reset, active low
   input  wire logic clk_in,   // clock level to gate
   input  wire logic gate_en,  // pass request
   output logic      clk_out   // gated level, one cycle behind
);
   scpm_pkg::scpm_gate_st_t st;
   scpm_pkg::scpm_gate_st_t n;

   always_comb begin
      n = st;
      if (!clk_in) begin
         n.en = gate_en;
      end
      n.out = clk_in & n.en;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
      end else begin
         st <= n;
      end
   end

   assign clk_out = st.out;
endmodule : scpm_clk_gate

/* File: core/scpm_ctrl.sv */
// top: clock selection, operating modes and register slave of the controller
// Notes on behaviour
// - a fast internal oscillator of about 8 MHz feeds the high-speed path
// - a slow internal oscillator of about 32 kHz feeds the low-speed path
// - system clock source is picked at run time by range bit and divider
// - divided fast clocks from /2 to /64 are offered besides fast and slow
// - timebase clock comes from the slow oscillator, for timebase and timers
// - the slow oscillator also clocks the watchdog
// - switching the system clock to slow stops the fast oscillator
// - six modes; CPU runs in normal and slow, stops in the other four
// - normal mode runs the CPU from fast divided 1..64, slow side running
// - slow mode runs from slow oscillator, fast off, timebase running
// - halt with idle enable low enters one of the two sleep modes
// - first sleep stops CPU, system clock, slow oscillator, timebase, watchdog
// - second sleep stops CPU, system, timebase; slow runs if watchdog enabled
// - halt with idle enable high and keep-clock low enters first idle
// - first idle stops CPU and system clock; slow and timebase keep running
// - halt with idle enable and keep-clock both high enters second idle
// - second idle gates the CPU, selected system oscillator keeps running
// - second idle keeps the slow oscillator and timebase clock running
// - range low: divider 0,1 slow; 2..7 fast /64,/32,/16,/8,/4,/2
// - range high picks undivided fast; range resets to one
// - sleep with watchdog or voltage detector on is second sleep, else first
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module scpm_ctrl (
   input  wire logic                    aclk,         // 100 MHz clock
   input  wire logic                    aresetn,      // synchronous reset, active low
   input  wire scpm_pkg::scpm_axi_req_t axi_req,      // register bus request
   output scpm_pkg::scpm_axi_rsp_t      axi_rsp,      // register bus answer
   input  wire logic                    halt_exec,    // halt instruction executed
   input  wire logic                    wake_event,   // wake-up from idle or sleep
   input  wire logic                    wdt_enable,   // watchdog switched on
   input  wire logic                    lvd_enable,   // low-voltage detector on
   output scpm_pkg::scpm_clk_t          clocks,       // generated clocks
   output scpm_pkg::scpm_mode_t         mode          // present operating mode
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      scpm_pkg::scpm_mode_t mode;
      logic [2:0]           clock_divider_select;
      logic                 clock_range_select;
      logic                 idle_on_halt_enable;
      logic                 keep_sysclk_in_idle;
      logic [3:0]           cur_code;
      logic                 fast_prev;
      logic [5:0]           div_cnt;
      logic                 sys_src;
      logic                 aw_held;
      logic [7:0]           awaddr;
      logic                 w_held;
      logic [7:0]           wdata;
      logic                 wstb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [7:0]           rdata;
      logic [1:0]           rresp;
   } scpm_st_t;

   scpm_st_t st;
   scpm_st_t n;

   logic       fast_lvl;
   logic       fast_rdy;
   logic       slow_lvl;
   logic       slow_rdy;
   logic       fast_en;
   logic       slow_en;
   logic       sys_en;
   logic       cpu_en;
   logic       tbc_en;
   logic       is_run;
   logic       tgt_slow;
   logic       run_slow;
   logic [3:0] want_code;
   logic       aw_hs;
   logic       w_hs;
   logic       ar_hs;

   // ----------------------------------------------------------------
   // oscillators and gates
   // ----------------------------------------------------------------
   scpm_osc #(.HALF_CYC(scpm_pkg::FAST_HALF_CYC)) u_fast_rc_osc (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .enable    (fast_en),
      .osc_out   (fast_lvl),
      .osc_ready (fast_rdy)
   );

   scpm_osc #(.HALF_CYC(scpm_pkg::SLOW_HALF_CYC)) u_slow_rc_osc (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .enable    (slow_en),
      .osc_out   (slow_lvl),
      .osc_ready (slow_rdy)
   );

   scpm_clk_gate u_sys_gate (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clk_in  (st.sys_src),
      .gate_en (sys_en),
      .clk_out (clocks.system_clock)
   );

   scpm_clk_gate u_cpu_gate (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clk_in  (st.sys_src),
      .gate_en (cpu_en),
      .clk_out (clocks.cpu_clock)
   );

   scpm_clk_gate u_tbc_gate (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clk_in  (slow_lvl),
      .gate_en (tbc_en),
      .clk_out (clocks.timebase_clock)
   );

   assign clocks.watchdog_clock = slow_lvl;
   assign clocks.fast_clock     = fast_lvl;
   assign mode                  = st.mode;

   // ----------------------------------------------------------------
   // mode-driven enables
   // ----------------------------------------------------------------
   assign is_run    = (st.mode == scpm_pkg::MD_NORMAL) || (st.mode == scpm_pkg::MD_SLOW);
   assign want_code = {st.clock_range_select, st.clock_divider_select};
   assign tgt_slow  = !st.clock_range_select
                      && (st.clock_divider_select <= scpm_pkg::DIV_SLOW_MAX);
   // slow mode only once the mux runs from slow: a divided fast level that is
   // still selected would freeze high if the fast oscillator stopped
   assign run_slow  = tgt_slow && src_is_slow(st.cur_code);
   assign fast_en   = (st.mode == scpm_pkg::MD_NORMAL)
                      || ((st.mode == scpm_pkg::MD_IDLE_CLOCK_RUNNING) && !src_is_slow(st.cur_code));
   assign slow_en   = (st.mode == scpm_pkg::MD_SLEEP_WATCHDOG_ALIVE) ? wdt_enable :
                      (st.mode != scpm_pkg::MD_SLEEP_ALL_OFF);
   assign sys_en    = is_run || (st.mode == scpm_pkg::MD_IDLE_CLOCK_RUNNING);
   assign cpu_en    = is_run;
   assign tbc_en    = (st.mode != scpm_pkg::MD_SLEEP_ALL_OFF)
                      && (st.mode != scpm_pkg::MD_SLEEP_WATCHDOG_ALIVE);

   // ----------------------------------------------------------------
   // source selection
   // ----------------------------------------------------------------
   function automatic logic src_is_slow(input logic [3:0] c);
      src_is_slow = !c[3] && (c[2:0] <= scpm_pkg::DIV_SLOW_MAX);
   endfunction : src_is_slow

   function automatic logic src_lvl(input logic [3:0] c, input logic f,
                                    input logic s, input logic [5:0] d);
      if (c[3]) begin
         src_lvl = f;
      end else if (c[2:0] <= scpm_pkg::DIV_SLOW_MAX) begin
         src_lvl = s;
      end else begin
         src_lvl = d[scpm_pkg::DIV_TOP - c[2:0]];
      end
   endfunction : src_lvl

   // ----------------------------------------------------------------
   // bus handshakes
   // ----------------------------------------------------------------
   assign axi_rsp.awready = !st.aw_held && !st.bvalid;
   assign axi_rsp.wready  = !st.w_held && !st.bvalid;
   assign axi_rsp.arready = !st.rvalid;
   assign axi_rsp.bvalid  = st.bvalid;
   assign axi_rsp.bresp   = st.bresp;
   assign axi_rsp.rvalid  = st.rvalid;
   assign axi_rsp.rdata   = {24'h000000, st.rdata};
   assign axi_rsp.rresp   = st.rresp;
   assign aw_hs           = axi_req.awvalid && axi_rsp.awready;
   assign w_hs            = axi_req.wvalid && axi_rsp.wready;
   assign ar_hs           = axi_req.arvalid && axi_rsp.arready;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      n = st;
      n.fast_prev = fast_lvl;
      if (fast_lvl && !st.fast_prev) begin
         n.div_cnt = st.div_cnt + 6'h01;
      end

      // switch only while output and new source are both low and the new
      // source is up, so no pulse is shortened; a low phase may stretch
      if (want_code != st.cur_code && !st.sys_src
          && !src_lvl(want_code, fast_lvl, slow_lvl, st.div_cnt)
          && (src_is_slow(want_code) ? slow_rdy : fast_rdy)) begin
         n.cur_code = want_code;
      end
      n.sys_src = src_lvl(n.cur_code, fast_lvl, slow_lvl, st.div_cnt);

      case (st.mode)
         scpm_pkg::MD_NORMAL, scpm_pkg::MD_SLOW: begin
            if (halt_exec) begin
               if (!st.idle_on_halt_enable) begin
                  n.mode = (wdt_enable || lvd_enable) ? scpm_pkg::MD_SLEEP_WATCHDOG_ALIVE
                                                      : scpm_pkg::MD_SLEEP_ALL_OFF;
               end else if (st.keep_sysclk_in_idle) begin
                  n.mode = scpm_pkg::MD_IDLE_CLOCK_RUNNING;
               end else begin
                  n.mode = scpm_pkg::MD_IDLE_CLOCK_STOPPED;
               end
            end else begin
               n.mode = run_slow ? scpm_pkg::MD_SLOW : scpm_pkg::MD_NORMAL;
            end
         end
         scpm_pkg::MD_IDLE_CLOCK_STOPPED, scpm_pkg::MD_IDLE_CLOCK_RUNNING,
         scpm_pkg::MD_SLEEP_ALL_OFF, scpm_pkg::MD_SLEEP_WATCHDOG_ALIVE: begin
            if (wake_event) begin
               n.mode = run_slow ? scpm_pkg::MD_SLOW : scpm_pkg::MD_NORMAL;
            end
         end
         default: begin
            n.mode = scpm_pkg::MD_NORMAL;
         end
      endcase

      // write path: address and data are taken in either order
      if (aw_hs) begin
         n.aw_held = 1'b1;
         n.awaddr  = axi_req.awaddr;
      end
      if (w_hs) begin
         n.w_held = 1'b1;
         n.wdata  = axi_req.wdata[7:0];
         n.wstb   = axi_req.wstrb[0];
      end
      if (st.aw_held && st.w_held && !st.bvalid) begin
         n.aw_held = 1'b0;
         n.w_held  = 1'b0;
         n.bvalid  = 1'b1;
         n.bresp   = scpm_pkg::RESP_OKAY;
         case (st.awaddr)
            scpm_pkg::ADDR_CTRL: begin
               if (st.wstb) begin
                  n.clock_divider_select = st.wdata[scpm_pkg::CTRL_DIV_LSB +: 3];
                  n.idle_on_halt_enable  = st.wdata[scpm_pkg::CTRL_IDLE_EN];
                  n.clock_range_select   = st.wdata[scpm_pkg::CTRL_RANGE];
               end
            end
            scpm_pkg::ADDR_EXT: begin
               if (st.wstb) begin
                  n.keep_sysclk_in_idle = st.wdata[scpm_pkg::EXT_KEEP_SYS];
               end
            end
            scpm_pkg::ADDR_MODE: begin
               n.bresp = scpm_pkg::RESP_OKAY;
            end
            default: begin
               n.bresp = scpm_pkg::RESP_DECERR;
            end
         endcase
      end
      if (st.bvalid && axi_req.bready) begin
         n.bvalid = 1'b0;
      end

      // read path: one cycle from address to data
      if (ar_hs) begin
         n.rvalid = 1'b1;
         n.rresp  = scpm_pkg::RESP_OKAY;
         n.rdata  = 8'h00;
         case (axi_req.araddr)
            scpm_pkg::ADDR_CTRL: begin
               n.rdata[scpm_pkg::CTRL_DIV_LSB +: 3]  = st.clock_divider_select;
               n.rdata[scpm_pkg::CTRL_SLOW_RDY]      = slow_rdy;
               n.rdata[scpm_pkg::CTRL_FAST_RDY]      = fast_rdy;
               n.rdata[scpm_pkg::CTRL_IDLE_EN]       = st.idle_on_halt_enable;
               n.rdata[scpm_pkg::CTRL_RANGE]         = st.clock_range_select;
            end
            scpm_pkg::ADDR_EXT: begin
               n.rdata[scpm_pkg::EXT_KEEP_SYS] = st.keep_sysclk_in_idle;
            end
            scpm_pkg::ADDR_MODE: begin
               n.rdata[2:0] = st.mode;
            end
            default: begin
               n.rresp = scpm_pkg::RESP_DECERR;
            end
         endcase
      end else if (st.rvalid && axi_req.rready) begin
         n.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st                      <= '0;
         st.mode                 <= scpm_pkg::MD_NORMAL;
         st.clock_divider_select <= scpm_pkg::RST_DIV;
         st.clock_range_select   <= scpm_pkg::RST_RANGE;
         st.idle_on_halt_enable  <= scpm_pkg::RST_IDLE_EN;
         st.keep_sysclk_in_idle  <= scpm_pkg::RST_KEEP_SYS;
         st.cur_code             <= {scpm_pkg::RST_RANGE, scpm_pkg::RST_DIV};
      end else begin
         st <= n;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_reset_ctrl;
      $rose(aresetn) |-> st.clock_range_select && st.idle_on_halt_enable
                         && (st.clock_divider_select == scpm_pkg::RST_DIV);
   endproperty
   a_reset_ctrl: assert property (p_reset_ctrl) else $error("bad control reset");

   property p_sleep_pick;
      is_run && halt_exec && !st.idle_on_halt_enable
      |=> st.mode == (($past(wdt_enable) || $past(lvd_enable)) ? scpm_pkg::MD_SLEEP_WATCHDOG_ALIVE
                                                               : scpm_pkg::MD_SLEEP_ALL_OFF);
   endproperty
   a_sleep_pick: assert property (p_sleep_pick) else $error("wrong sleep mode");

   property p_idle_clock_stopped_pick;
      is_run && halt_exec && st.idle_on_halt_enable && !st.keep_sysclk_in_idle
      |=> st.mode == scpm_pkg::MD_IDLE_CLOCK_STOPPED;
   endproperty
   a_idle_clock_stopped_pick: assert property (p_idle_clock_stopped_pick) else $error("idle_clock_stopped not entered");

   property p_idle_clock_running_pick;
      is_run && halt_exec && st.idle_on_halt_enable && st.keep_sysclk_in_idle
      |=> st.mode == scpm_pkg::MD_IDLE_CLOCK_RUNNING;
   endproperty
   a_idle_clock_running_pick: assert property (p_idle_clock_running_pick) else $error("idle_clock_running not entered");

   property p_sleep_all_off_off;
      // a high phase under way may finish; no new pulse may start
      (st.mode == scpm_pkg::MD_SLEEP_ALL_OFF) [*3]
      |-> !slow_en && !$rose(clocks.cpu_clock) && !$rose(clocks.system_clock)
          && !$rose(clocks.timebase_clock);
   endproperty
   a_sleep_all_off_off: assert property (p_sleep_all_off_off) else $error("clock alive in sleep_all_off");

   property p_sleep_watchdog_alive_wd;
      (st.mode == scpm_pkg::MD_SLEEP_WATCHDOG_ALIVE) |-> (slow_en == wdt_enable) && !tbc_en && !sys_en;
   endproperty
   a_sleep_watchdog_alive_wd: assert property (p_sleep_watchdog_alive_wd) else $error("sleep_watchdog_alive clocks wrong");

   property p_slow_fast_off;
      (st.mode == scpm_pkg::MD_SLOW) |-> !fast_en && slow_en && tbc_en && cpu_en;
   endproperty
   a_slow_fast_off: assert property (p_slow_fast_off) else $error("fast on in slow");

   property p_idle_clock_running_run;
      (st.mode == scpm_pkg::MD_IDLE_CLOCK_RUNNING) |-> sys_en && slow_en && tbc_en && !cpu_en;
   endproperty
   a_idle_clock_running_run: assert property (p_idle_clock_running_run) else $error("idle_clock_running clocks wrong");

   property p_no_runt;
      $fell(st.sys_src) |-> $past(st.sys_src, 2);
   endproperty
   a_no_runt: assert property (p_no_runt) else $error("runt system clock pulse");
endmodule : scpm_ctrl

/* File: bench/scpm_clk_sink.sv */
// clock consumer model: counts rising edges of every delivered clock
`timescale 1ns/1ps
module scpm_clk_sink (
   input  wire logic                aclk,   // sampling clock
   input  wire logic                clr,    // clear the counts
   input  wire scpm_pkg::scpm_clk_t clk_in, // delivered clocks
   output int                       cnt [5] // rising edges seen, per clock
);
   scpm_pkg::scpm_clk_t prev;
   // falling edge: the clock levels are registered on the rising edge
   always @(negedge aclk) begin
      prev <= clk_in;
      for (int i = 0; i < 5; i++) begin
         cnt[i] <= clr ? 0 : cnt[i] + int'(clk_in[i] & ~prev[i]);
      end
   end
endmodule : scpm_clk_sink

/* File: bench/scpm_ctrl_bench.sv */
// self-checking bench of the clock and power-mode controller
`timescale 1ns/1ps
module scpm_ctrl_bench;
   logic                    aclk, aresetn, halt, wake, wdt, low_voltage_detector, clr;
   scpm_pkg::scpm_axi_req_t req;
   scpm_pkg::scpm_axi_rsp_t rsp, rs;
   scpm_pkg::scpm_clk_t     clocks, cs;
   scpm_pkg::scpm_mode_t    mode, ms;
   int                      cnt [5];
   int                      n_fail = 0;
   int                      num_checks = 0;
   logic [3:0]              hc [5] = '{4'hc, 4'h8, 4'h0, 4'h2, 4'h1};
   logic [2:0]              hr [5] = '{3'h7, 3'h3, 3'h0, 3'h1, 3'h0};
   logic [2:0]              hm [5] = '{3'h3, 3'h2, 3'h7, 3'h6, 3'h6};

   scpm_ctrl i_scpm_ctrl (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .halt_exec(halt), .wake_event(wake), .wdt_enable(wdt), .lvd_enable(low_voltage_detector),
      .clocks(clocks), .mode(mode));
   scpm_clk_sink i_scpm_clk_sink (.aclk(aclk), .clr(clr), .clk_in(clocks), .cnt(cnt));

   // copies taken mid-cycle hold what the next rising edge samples
   always @(negedge aclk) begin
      rs <= rsp;
      cs <= clocks;
      ms <= mode;
   end

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      req.awvalid <= 1'b1;
      req.awaddr  <= a;
      req.wvalid  <= 1'b1;
      req.wdata   <= d;
      req.wstrb   <= 4'hf;
      req.bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (rs.awready) req.awvalid <= 1'b0;
         if (rs.wready) req.wvalid <= 1'b0;
      end while (rs.bvalid !== 1'b1);
      // bready stays up, so a call that follows at once drives it only once
      chk({30'h0, rs.bresp}, {30'h0, er});
   endtask : wr

   task automatic rdr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input logic [1:0] er);
      req.arvalid <= 1'b1;
      req.araddr  <= a;
      req.rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (rs.arready) req.arvalid <= 1'b0;
      end while (rs.rvalid !== 1'b1);
      chk(rs.rdata & m, e);
      chk({30'h0, rs.rresp}, {30'h0, er});
   endtask : rdr

   // a source switch settles within one new period, waited out first; a low
   // phase stretched by the switch is then skipped by judging the third rise
   task automatic per(input int i, input int e);
      int   n, k, last, p;
      logic pv;
      n = 0;
      k = 0;
      last = 0;
      p = 0;
      repeat (e) @(posedge aclk);
      pv = cs[i];
      while (k < 3) begin
         @(posedge aclk);
         n++;
         if (cs[i] === 1'b1 && pv === 1'b0) begin
            k++;
            p = n - last;
            last = n;
         end
         pv = cs[i];
      end
      chk(p, e);
   endtask : per

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict

   initial begin
      #900000;
      n_fail++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      req = '0;
      {halt, wake, wdt, low_voltage_detector, clr, aresetn} = 6'h2;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rdr(scpm_pkg::ADDR_CTRL, 32'hf3, 32'h3, scpm_pkg::RESP_OKAY);
      rdr(scpm_pkg::ADDR_EXT, 32'hff, 32'h0, scpm_pkg::RESP_OKAY);
      rdr(scpm_pkg::ADDR_MODE, 32'h7, 32'h0, scpm_pkg::RESP_OKAY);
      rdr(8'h0c, 32'hffffffff, 32'h0, scpm_pkg::RESP_DECERR);
      wr(8'h0c, 32'h1, scpm_pkg::RESP_DECERR);
      $display("test registers done");
      repeat (7000) @(posedge aclk);
      rdr(scpm_pkg::ADDR_CTRL, 32'hc, 32'hc, scpm_pkg::RESP_OKAY);
      per(4, 2 * scpm_pkg::FAST_HALF_CYC);
      per(3, 2 * scpm_pkg::FAST_HALF_CYC);
      for (int d = 2; d < 8; d++) begin
         wr(scpm_pkg::ADDR_CTRL, {24'h0, d[2:0], 5'h2}, scpm_pkg::RESP_OKAY);
         per(4, (2 * scpm_pkg::FAST_HALF_CYC) << (8 - d));
         chk({29'h0, ms}, 32'h0);
      end
      $display("test dividers done");
      wr(scpm_pkg::ADDR_CTRL, 32'h2, scpm_pkg::RESP_OKAY);
      per(4, 2 * scpm_pkg::SLOW_HALF_CYC);
      chk({29'h0, ms}, 32'h1);
      per(2, 2 * scpm_pkg::SLOW_HALF_CYC);
      clr <= 1'b0;
      repeat (200) @(posedge aclk);
      chk(cnt[0], 0);
      wr(scpm_pkg::ADDR_CTRL, 32'h3, scpm_pkg::RESP_OKAY);
      repeat (100) @(posedge aclk);
      $display("test slow done");
      for (int j = 0; j < 5; j++) begin
         wr(scpm_pkg::ADDR_CTRL, {30'h0, hc[j][3], 1'b1}, scpm_pkg::RESP_OKAY);
         wr(scpm_pkg::ADDR_EXT, {24'h0, hc[j][2], 7'h0}, scpm_pkg::RESP_OKAY);
         wdt  <= hc[j][1];
         low_voltage_detector  <= hc[j][0];
         halt <= 1'b1;
         @(posedge aclk);
         halt <= 1'b0;
         repeat (20) @(posedge aclk);
         chk({29'h0, ms}, {29'h0, hm[j]});
         clr <= 1'b1;
         @(posedge aclk);
         clr <= 1'b0;
         repeat (3500) @(posedge aclk);
         chk(cnt[3], 0);
         chk({31'h0, cnt[4] != 0}, {31'h0, hr[j][2]});
         chk({31'h0, cnt[2] != 0}, {31'h0, hr[j][1]});
         chk({31'h0, cnt[1] != 0}, {31'h0, hr[j][0]});
         wake <= 1'b1;
         @(posedge aclk);
         wake <= 1'b0;
         @(posedge aclk);
         chk({29'h0, ms}, 32'h0);
         repeat (100) @(posedge aclk);
      end
      $display("test halt modes done");
      print_verdict();
   end
endmodule : scpm_ctrl_bench
